// ==== bsp_params.svh ====
// Constants for the boundary-scan and in-circuit programming port
`ifndef BSP_PARAMS_SVH
`define BSP_PARAMS_SVH

// Pin counts and chain sizing
`define BSP_IO_PINS 96
`define BSP_IN_PINS 4
`define BSP_MACROCELLS 16
`define BSP_CAP_STAGES 3
`define BSP_ISP_W 32

// Bit positions of the four test-port pins in the pin vectors
`define BSP_PIN_CLK 0
`define BSP_PIN_MODE 1
`define BSP_PIN_DIN 2
`define BSP_PIN_DOUT 3

// Pull-up mask: mode-select and data-input pins only
`define BSP_PULLUP_MASK 4'h6

// Instruction register
`define BSP_IR_W 4
`define BSP_IR_CAPTURE 4'h1
`define BSP_INS_EXTEST 4'h0
`define BSP_INS_SAMPLE 4'h1
`define BSP_INS_IDCODE 4'h2
`define BSP_INS_PROG 4'h8
`define BSP_INS_BYPASS 4'hf

// Identification word; value is arbitrary, bit 0 must stay set
`define BSP_IDCODE 32'h0a5c_3001

`endif

// ==== bsp_pkg.sv ====
// Types shared by the boundary-scan port design
package bsp_pkg;

  // Test access port controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bsp_tap_state_t;

endpackage

// ==== bsp_scan_cell.sv ====
// One boundary-scan cell: three capture stages in series, one or two update stages
`timescale 1ns/100ps
module bsp_scan_cell #(
  parameter int UPD_STAGES = 2
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Controls from the port controller
  input wire logic i_cap,
  input wire logic i_shift,
  input wire logic i_upd,
  // Serial path and parallel sample {in, oe, out}
  input wire logic i_si,
  input wire logic [2:0] i_par,
  output logic o_so,
  // Update stages {oe, out}
  output logic [1:0] o_upd
);

  logic [2:0] cap_q;
  logic upd0_q;
  logic upd1_q;

  if (UPD_STAGES < 1 || UPD_STAGES > 2) begin : g_chk
    $error("bsp_scan_cell: UPD_STAGES must be 1 or 2");
  end

  // Capture stages sample, shift, and feed the update stages
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cap_q <= 3'h0;
    end else if (i_cap) begin
      cap_q <= i_par; // [RULE8]
    end else if (i_shift) begin
      cap_q <= {cap_q[1:0], i_si}; // [RULE8]
    end
  end

  // Update stage for the data value
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      upd0_q <= 1'b0;
    end else if (i_upd) begin
      upd0_q <= cap_q[0]; // [RULE8]
    end
  end

  // Optional second update stage for the enable; macrocell cells leave it out
  if (UPD_STAGES == 2) begin : g_oe
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        upd1_q <= 1'b0;
      end else if (i_upd) begin
        upd1_q <= cap_q[1]; // [RULE5]
      end
    end
  end else begin : g_no_oe
    assign upd1_q = 1'b0;
  end

  assign o_so = cap_q[2];
  assign o_upd = {upd1_q, upd0_q};

endmodule

// ==== bsp_tap_top.sv ====
// Boundary-scan test access port with scan chain and in-circuit programming path
//
// Function
// RULE1 - No test reset pin; power-up reset forces the controller to its reset state.
// RULE2 - Sample/preload, external test, bypass and identification instructions are supported.
// RULE3 - Every input and I/O pin has its own scan_cell, controllable and observable; input-pin cells only observe, as their pad enables stay low.
// RULE4 - Chain sized for up to 96 I/O pins plus four input pins.
// RULE5 - A cell holds three capture stages and at most two update stages.
// RULE6 - Two cell kinds: one for input and I/O pins, one for macrocells.
// RULE7 - All cells form one chain from test data input to test data output.
// RULE8 - Capture stages sample live signals, shift serially, and load update stages.
// RULE9 - Capture, shift and update controls come from the controller, not pins.
// RULE10 - In-circuit programming runs over the same four pins with a standard sequence.
// RULE11 - With the port disabled by configuration, its four pins are plain user I/O.
// RULE12 - Optional pull-up on mode-select and data-input pins, chosen at design time.
// RULE13 - Bypass puts a single-bit register between data input and data output.
`timescale 1ns/100ps
`include "bsp_params.svh"
module bsp_tap_top import bsp_pkg::*; #(
  parameter int IO_PINS = `BSP_IO_PINS,
  parameter int IN_PINS = `BSP_IN_PINS,
  parameter int MACROCELLS = `BSP_MACROCELLS,
  parameter int ISP_W = `BSP_ISP_W,
  parameter bit JTAG_EN = 1'b1,
  parameter bit PULLUP_EN = 1'b1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Test-port pins {dout, din, mode, clk}, two-way
  input wire logic [3:0] i_jpin_in,
  output logic [3:0] o_jpin_out,
  output logic [3:0] o_jpin_oe,
  output logic [3:0] o_jpin_pullup,
  // User logic side of the test-port pins when the port is disabled
  input wire logic [3:0] i_jusr_out,
  input wire logic [3:0] i_jusr_oe,
  output logic [3:0] o_jusr_in,
  // Device pads: I/O pins low, dedicated input pins on top
  input wire logic [IO_PINS+IN_PINS-1:0] i_pad_in,
  output logic [IO_PINS+IN_PINS-1:0] o_pad_out,
  output logic [IO_PINS+IN_PINS-1:0] o_pad_oe,
  // Core logic side of the pads
  input wire logic [IO_PINS+IN_PINS-1:0] i_core_out,
  input wire logic [IO_PINS+IN_PINS-1:0] i_core_oe,
  output logic [IO_PINS+IN_PINS-1:0] o_core_in,
  // Macrocell values
  input wire logic [MACROCELLS-1:0] i_mc_val,
  output logic [MACROCELLS-1:0] o_mc_val,
  // Programming word out
  output logic [ISP_W-1:0] o_prog_word,
  output logic o_prog_stb,
  output logic o_prog_mode
);

  localparam int NP = IO_PINS + IN_PINS;
  localparam int NCELL = NP + MACROCELLS;

  // Refuse sizes the chain cannot serve
  if (IO_PINS < 1 || IO_PINS > `BSP_IO_PINS || IN_PINS < 0 || IN_PINS > `BSP_IN_PINS ||
      MACROCELLS < 1 || ISP_W < 1) begin : g_chk
    $error("bsp_tap_top: pin, macrocell or word width out of range"); // [RULE4]
  end

  bsp_tap_state_t state_q;
  bsp_tap_state_t state_d;
  logic [3:0] jin_s1_q;
  logic [3:0] jin_s2_q;
  logic tck_prev_q;
  logic [NP-1:0] pad_s1_q;
  logic [NP-1:0] pad_s2_q;
  logic [`BSP_IR_W-1:0] ir_sr_q;
  logic [`BSP_IR_W-1:0] ir_q;
  logic [31:0] id_sr_q;
  logic byp_q;
  logic [ISP_W-1:0] isp_sr_q;
  logic [3:0] jpin_out_q;
  logic [3:0] jpin_oe_q;
  logic [3:0] jusr_in_q;
  logic [NP-1:0] pad_out_q;
  logic [NP-1:0] pad_oe_q;
  logic [NP-1:0] core_in_q;
  logic [MACROCELLS-1:0] mc_val_q;
  logic [ISP_W-1:0] prog_word_q;
  logic prog_stb_q;
  logic prog_mode_q;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic bsr_sel;
  logic extest;
  logic cap_en;
  logic sh_en;
  logic upd_en;
  logic tdo_bit;
  logic [NCELL:0] link;
  logic [1:0] cell_upd [NCELL];

  // Two-flop synchronisers on every pin input; the link clock is sampled, not used as a clock
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      jin_s1_q <= 4'h0;
      jin_s2_q <= 4'h0;
      tck_prev_q <= 1'b0;
      pad_s1_q <= '0;
      pad_s2_q <= '0;
    end else begin
      jin_s1_q <= i_jpin_in;
      jin_s2_q <= jin_s1_q;
      tck_prev_q <= jin_s2_q[`BSP_PIN_CLK];
      pad_s1_q <= i_pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  // Test clock edges and sampled serial inputs
  assign tck_rise = JTAG_EN && jin_s2_q[`BSP_PIN_CLK] && !tck_prev_q;
  assign tck_fall = JTAG_EN && !jin_s2_q[`BSP_PIN_CLK] && tck_prev_q;
  assign tms = jin_s2_q[`BSP_PIN_MODE];
  assign tdi = jin_s2_q[`BSP_PIN_DIN];

  // Controller next state; follows the standard sixteen-state graph
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
      default: state_d = ST_RESET;
    endcase
  end

  // Power-up reset stands in for the missing test reset pin
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q <= ST_RESET; // [RULE1]
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // Instruction shift and update; reset selects identification
  always_ff @(posedge i_mclk) begin
    if (i_rst || state_q == ST_RESET) begin
      ir_sr_q <= `BSP_IR_CAPTURE;
      ir_q <= `BSP_INS_IDCODE; // [RULE2]
    end else if (tck_rise && state_q == ST_CAP_IR) begin
      ir_sr_q <= `BSP_IR_CAPTURE;
    end else if (tck_rise && state_q == ST_SH_IR) begin
      ir_sr_q <= {tdi, ir_sr_q[`BSP_IR_W-1:1]};
    end else if (tck_fall && state_q == ST_UPD_IR) begin
      ir_q <= ir_sr_q; // [RULE2]
    end
  end

  // Cell controls made here from controller state, never from pins
  assign bsr_sel = (ir_q == `BSP_INS_EXTEST) || (ir_q == `BSP_INS_SAMPLE);
  assign extest = (ir_q == `BSP_INS_EXTEST);
  assign cap_en = tck_rise && bsr_sel && state_q == ST_CAP_DR; // [RULE9]
  assign sh_en = tck_rise && bsr_sel && state_q == ST_SH_DR; // [RULE9]
  assign upd_en = tck_fall && bsr_sel && state_q == ST_UPD_DR; // [RULE9]

  // One chain: pin cells first from the data input, macrocell cells last
  assign link[0] = tdi; // [RULE7]
  for (genvar k = 0; k < NCELL; k++) begin : g_cell
    if (k < NP) begin : g_pin
      bsp_scan_cell #(.UPD_STAGES(2)) u_cell ( // [RULE3] [RULE6]
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_cap(cap_en),
        .i_shift(sh_en),
        .i_upd(upd_en),
        .i_si(link[k]),
        .i_par({pad_s2_q[k], i_core_oe[k], i_core_out[k]}),
        .o_so(link[k+1]),
        .o_upd(cell_upd[k])
      );
    end else begin : g_mc
      bsp_scan_cell #(.UPD_STAGES(1)) u_cell ( // [RULE6]
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_cap(cap_en),
        .i_shift(sh_en),
        .i_upd(upd_en),
        .i_si(link[k]),
        .i_par({i_mc_val[k-NP], 1'b0, i_mc_val[k-NP]}),
        .o_so(link[k+1]),
        .o_upd(cell_upd[k])
      );
    end
  end

  // Pads follow the cells under external test, the core otherwise
  for (genvar p = 0; p < NP; p++) begin : g_pad
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        pad_out_q[p] <= 1'b0;
        pad_oe_q[p] <= 1'b0;
      end else if (extest) begin
        pad_out_q[p] <= cell_upd[p][0]; // [RULE3]
        pad_oe_q[p] <= (p < IO_PINS) ? cell_upd[p][1] : 1'b0;
      end else begin
        pad_out_q[p] <= i_core_out[p];
        pad_oe_q[p] <= (p < IO_PINS) ? i_core_oe[p] : 1'b0;
      end
    end
  end

  // Macrocell outputs and core inputs
  for (genvar m = 0; m < MACROCELLS; m++) begin : g_mcv
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        mc_val_q[m] <= 1'b0;
      end else begin
        mc_val_q[m] <= extest ? cell_upd[NP+m][0] : i_mc_val[m];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      core_in_q <= '0;
    end else begin
      core_in_q <= pad_s2_q;
    end
  end

  // Bypass bit and identification register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      byp_q <= 1'b0;
      id_sr_q <= `BSP_IDCODE;
    end else if (tck_rise && state_q == ST_CAP_DR) begin
      byp_q <= 1'b0;
      id_sr_q <= `BSP_IDCODE; // [RULE2]
    end else if (tck_rise && state_q == ST_SH_DR) begin
      byp_q <= tdi; // [RULE13]
      id_sr_q <= {tdi, id_sr_q[31:1]};
    end
  end

  // Programming word: shifted in under the programming instruction, handed on at update
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      isp_sr_q <= '0;
      prog_word_q <= '0;
      prog_stb_q <= 1'b0;
      prog_mode_q <= 1'b0;
    end else begin
      prog_mode_q <= (ir_q == `BSP_INS_PROG); // [RULE10]
      prog_stb_q <= tck_fall && state_q == ST_UPD_DR && ir_q == `BSP_INS_PROG;
      if (tck_rise && state_q == ST_SH_DR && ir_q == `BSP_INS_PROG) begin
        isp_sr_q <= {tdi, isp_sr_q[ISP_W-1:1]}; // [RULE10]
      end
      if (tck_fall && state_q == ST_UPD_DR && ir_q == `BSP_INS_PROG) begin
        prog_word_q <= isp_sr_q;
      end
    end
  end

  // Serial output choice; unknown codes fall to bypass
  always_comb begin
    tdo_bit = byp_q; // [RULE13]
    if (state_q == ST_SH_IR) begin
      tdo_bit = ir_sr_q[0];
    end else if (bsr_sel) begin
      tdo_bit = link[NCELL]; // [RULE7]
    end else if (ir_q == `BSP_INS_IDCODE) begin
      tdo_bit = id_sr_q[0];
    end else if (ir_q == `BSP_INS_PROG) begin
      tdo_bit = isp_sr_q[0];
    end
  end

  // Test-port pins: data output changes on the falling test clock; user I/O when disabled
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      jpin_out_q <= 4'h0;
      jpin_oe_q <= 4'h0;
      jusr_in_q <= 4'h0;
    end else if (!JTAG_EN) begin
      jpin_out_q <= i_jusr_out; // [RULE11]
      jpin_oe_q <= i_jusr_oe; // [RULE11]
      jusr_in_q <= jin_s2_q;
    end else begin
      jusr_in_q <= 4'h0;
      if (tck_fall) begin
        jpin_out_q[`BSP_PIN_DOUT] <= tdo_bit;
        jpin_oe_q[`BSP_PIN_DOUT] <= (state_q == ST_SH_DR) || (state_q == ST_SH_IR);
      end
    end
  end

  // Pull-up enable is fixed at build time; a register so it is clean from reset
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_jpin_pullup <= 4'h0;
    end else begin
      o_jpin_pullup <= PULLUP_EN ? `BSP_PULLUP_MASK : 4'h0; // [RULE12]
    end
  end

  assign o_jpin_out = jpin_out_q;
  assign o_jpin_oe = jpin_oe_q;
  assign o_jusr_in = jusr_in_q;
  assign o_pad_out = pad_out_q;
  assign o_pad_oe = pad_oe_q;
  assign o_core_in = core_in_q;
  assign o_mc_val = mc_val_q;
  assign o_prog_word = prog_word_q;
  assign o_prog_stb = prog_stb_q;
  assign o_prog_mode = prog_mode_q;

endmodule

// ==== bsp_tap_chk.sv ====
// Checker for the boundary-scan port outputs
`timescale 1ns/100ps
module bsp_tap_chk #(
  parameter int IO_PINS = 96,
  parameter int IN_PINS = 4,
  parameter int ISP_W = 32,
  parameter bit JTAG_EN = 1'b1,
  parameter bit PULLUP_EN = 1'b1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Watched ports
  input wire logic [3:0] i_jpin_in,
  input wire logic [3:0] o_jpin_out,
  input wire logic [3:0] o_jpin_oe,
  input wire logic [3:0] o_jpin_pullup,
  input wire logic [IO_PINS+IN_PINS-1:0] o_pad_oe,
  input wire logic [ISP_W-1:0] o_prog_word,
  input wire logic o_prog_stb,
  input wire logic o_prog_mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Outputs come up quiet after reset
  property p_rst;
    $fell(i_rst) |-> o_jpin_oe == 4'h0 && !o_prog_stb && !o_prog_mode;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_pullup;
    !i_rst |=> o_jpin_pullup == (PULLUP_EN ? 4'h6 : 4'h0);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up enables wrong");
  property p_stb_pulse;
    o_prog_stb |=> !o_prog_stb;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe too long");
  property p_stb_mode;
    o_prog_stb |-> o_prog_mode;
  endproperty
  a_stb_mode: assert property (p_stb_mode) else $error("strobe outside programming");
  // A new word is always announced by the strobe
  property p_word;
    $changed(o_prog_word) |-> ##[0:1] o_prog_stb;
  endproperty
  a_word: assert property (p_word) else $error("word changed without strobe");
  // Data-out and its enable move only after a falling link clock
  property p_tdo_oe;
    $changed(o_jpin_oe[3]) |-> !$past(i_jpin_in[0], 3);
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("data-out enable on rising clock");
  property p_tdo_out;
    $changed(o_jpin_out[3]) |-> !$past(i_jpin_in[0], 3);
  endproperty
  a_tdo_out: assert property (p_tdo_out) else $error("data-out moved on rising clock");
  property p_mode;
    $changed(o_prog_mode) |-> !$past(i_jpin_in[0], 3);
  endproperty
  a_mode: assert property (p_mode) else $error("instruction changed off falling clock");
  property p_in_oe;
    o_pad_oe[IO_PINS+IN_PINS-1:IO_PINS] == '0;
  endproperty
  a_in_oe: assert property (p_in_oe) else $error("input pin driven");
  property p_pin_oe;
    JTAG_EN |-> o_jpin_oe[2:0] == 3'h0;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("port input pin driven");
endmodule

bind bsp_tap_top bsp_tap_chk #(.IO_PINS(IO_PINS), .IN_PINS(IN_PINS), .ISP_W(ISP_W),
  .JTAG_EN(JTAG_EN), .PULLUP_EN(PULLUP_EN)) u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_jpin_in(i_jpin_in), .o_jpin_out(o_jpin_out), .o_jpin_oe(o_jpin_oe),
  .o_jpin_pullup(o_jpin_pullup), .o_pad_oe(o_pad_oe), .o_prog_word(o_prog_word),
  .o_prog_stb(o_prog_stb), .o_prog_mode(o_prog_mode));

// ==== bsp_jtag_host.sv ====
// Model of the external test controller on the four-pin port
`timescale 1ns/100ps
module bsp_jtag_host (
  // Pacing clock
  input wire logic i_mclk,
  // Port pins
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  // Link clock stands still low; data line rests at its pull-up level
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // One 80 ns link cycle, entered at a falling mclk; inputs held across the rise
  task automatic tap(input logic tms, input logic tdi, output logic tdo);
    o_tck = 1'b0;
    o_tms = tms;
    o_tdi = tdi;
    repeat (10) @(negedge i_mclk);
    tdo = i_tdo;
    o_tck = 1'b1;
    repeat (10) @(negedge i_mclk);
  endtask
  // Bring the link clock back to its low rest level, so a reset sees no stray edge
  task automatic park;
    o_tck = 1'b0;
    repeat (10) @(negedge i_mclk);
  endtask
endmodule

// ==== bsp_tap_top_tb_top.sv ====
// Self-checking bench for the boundary-scan port
`timescale 1ns/100ps
`include "bsp_params.svh"
module bsp_tap_top_tb_top;
  localparam int NP = 100;
  localparam int NC = NP + 16;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic tck, tms, tdi, o_prog_stb, o_prog_mode;
  logic tdo_last_q = 1'b0;
  logic [3:0] i_jpin_in, o_jpin_out, o_jpin_oe, o_jpin_pullup, o_jusr_in;
  logic [NP-1:0] i_pad_in = '0, i_core_out = '0, i_core_oe = '0;
  logic [NP-1:0] o_pad_out, o_pad_oe, o_core_in;
  logic [15:0] i_mc_val = '0, o_mc_val;
  logic [31:0] o_prog_word;
  logic [511:0] sin, sout;
  int bad_count = 0, checked = 0, stb_cnt = 0;

  always #2 i_mclk = ~i_mclk;
  // Released data-out wire shows the inverse of its last level, not a stale copy
  assign i_jpin_in = {o_jpin_oe[3] ? o_jpin_out[3] : ~tdo_last_q, tdi, tms, tck};
  always @(posedge i_mclk) begin
    if (o_jpin_oe[3]) tdo_last_q <= o_jpin_out[3];
    if (o_prog_stb === 1'b1) stb_cnt++;
  end

  bsp_tap_top u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_jpin_in(i_jpin_in),
    .o_jpin_out(o_jpin_out), .o_jpin_oe(o_jpin_oe), .o_jpin_pullup(o_jpin_pullup),
    .i_jusr_out(4'h0), .i_jusr_oe(4'h0), .o_jusr_in(o_jusr_in), .i_pad_in(i_pad_in),
    .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .i_core_out(i_core_out),
    .i_core_oe(i_core_oe), .o_core_in(o_core_in), .i_mc_val(i_mc_val),
    .o_mc_val(o_mc_val), .o_prog_word(o_prog_word), .o_prog_stb(o_prog_stb),
    .o_prog_mode(o_prog_mode));
  bsp_jtag_host u_host (.i_mclk(i_mclk), .i_tdo(i_jpin_in[3]), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Mode-select walk, LSB first, data line idle high
  task automatic walk(input logic [7:0] v, input int n);
    logic d;
    for (int i = 0; i < n; i++) u_host.tap(v[i], 1'b1, d);
  endtask
  // Idle to instruction shift, load code, back to idle
  task automatic ir(input logic [3:0] c);
    logic [3:0] q;
    walk(8'h03, 4);
    for (int i = 0; i < 4; i++) u_host.tap(i == 3, c[i], q[i]);
    walk(8'h01, 2);
    check(q, 4'h1);
  endtask
  // Idle to data shift of n bits from sin into sout, through update to idle
  task automatic dr(input int n);
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) u_host.tap(i == n - 1, sin[i], sout[i]);
    walk(8'h01, 2);
  endtask

  task automatic t_reset_id;
    walk(8'h1f, 6);
    ir(`BSP_INS_BYPASS);
    // Reset in mid-run must restore the identification instruction
    u_host.park();
    i_rst = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_mclk);
    check(o_jpin_pullup, `BSP_PULLUP_MASK);
    check(o_jusr_in, 4'h0);
    walk(8'h00, 1);
    sin = '0;
    dr(32);
    check(sout[31:0], `BSP_IDCODE);
    $display("Reset and identification test done");
  endtask
  task automatic t_bypass;
    for (int k = 0; k < 2; k++) begin
      ir(k ? 4'h3 : `BSP_INS_BYPASS);
      sin = {480'h0, 32'ha5c3_0f96};
      dr(33);
      check(sout[32:0], {sin[31:0], 1'b0});
    end
    $display("Bypass test done");
  endtask
  task automatic t_scan;
    i_pad_in = {25{4'h9}};
    i_mc_val = 16'h3c5a;
    i_core_out = {25{4'h6}};
    i_core_oe = {25{4'h3}};
    ir(`BSP_INS_SAMPLE);
    check(o_pad_out, i_core_out);
    check(o_pad_oe, {4'h0, i_core_oe[95:0]});
    sin = '1;
    dr(3 * NC);
    for (int c = 0; c < NC; c++) begin
      check(sout[3 * (NC - 1 - c)], c < NP ? i_pad_in[c] : i_mc_val[c - NP]);
    end
    // Preloaded ones now drive every I/O pin and macrocell
    ir(`BSP_INS_EXTEST);
    check(o_pad_out, {NP{1'b1}});
    check(o_pad_oe, {4'h0, {96{1'b1}}});
    check(o_mc_val, 16'hffff);
    check(o_core_in, i_pad_in);
    ir(`BSP_INS_BYPASS);
    check(o_pad_out, i_core_out);
    $display("Sample and external test done");
  endtask
  task automatic t_prog;
    ir(`BSP_INS_PROG);
    check(o_prog_mode, 1'b1);
    sin = {480'h0, 32'h5a3c_0ff1};
    stb_cnt = 0;
    dr(32);
    check(o_prog_word, sin[31:0]);
    check(stb_cnt, 1);
    ir(`BSP_INS_BYPASS);
    check(o_prog_mode, 1'b0);
    $display("Programming test done");
  endtask

  initial begin
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_mclk);
    t_reset_id();
    t_bypass();
    t_scan();
    t_prog();
    tally_and_finish();
  end
  // Watchdog: the sequence needs about 12000 clocks
  initial begin
    repeat (60000) @(posedge i_mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule
